// File: src/pbdr_bin_stage.sv
`timescale 1ns/1ps
`include "pbdr_regs.svh"

module pbdr_bin_stage #(
	parameter bit VERT = 1'b0,
	parameter int MAX_W = 2048
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire pbdr_pkg::pbdr_bin_cfg_t cfg_i,
	pbdr_pix_if.snk in_if,
	pbdr_pix_if.src out_if
);
	localparam int DEPTH = VERT ? 2 * MAX_W : 2;
	localparam int IDX_W = $clog2(DEPTH);
	localparam int COL_W = $clog2(MAX_W);

	logic [`PBDR_ACC_W-1:0] acc_mem [DEPTH];
	logic [COL_W-1:0] col_reg;
	logic [COL_W-1:0] cur_col;
	logic [2:0] kpos_reg;
	logic [2:0] krow_reg;
	logic [2:0] cur_kpos;
	logic [2:0] cur_krow;
	logic [2:0] k;
	logic [2:0] wrap;
	logic [1:0] member;
	logic [1:0] wt;
	logic phase;
	logic emit;
	logic sof_pend_reg;
	logic sol_pend_reg;
	logic [IDX_W-1:0] idx;
	logic [`PBDR_ACC_W-1:0] term;
	logic [`PBDR_ACC_W-1:0] total;

	always_comb
	begin
		wrap = {cfg_i.factor, 1'b1};
		cur_col = in_if.sol ? '0 : col_reg;
		cur_kpos = in_if.sol ? 3'h0 : kpos_reg;
		cur_krow = krow_reg;
		if (in_if.sol)
			cur_krow = (in_if.sof || krow_reg == wrap) ? 3'h0 : krow_reg + 3'h1;
		k = VERT ? cur_krow : cur_kpos;
		// even/odd positions are the two mosaic phases, never mixed
		phase = k[0];
		member = k[2:1];
		// horizontal: the cast keeps only the phase bit
		idx = IDX_W'({cur_col, phase});
		wt = pbdr_pkg::bin_weight(cfg_i, member, phase);
		term = `PBDR_ACC_W'(in_if.data) * `PBDR_ACC_W'(wt);
		total = (member == 2'h0) ? term : acc_mem[idx] + term;
		// combine emits on the last member, subsample keeps the first
		emit = in_if.valid && member == (cfg_i.combine ? cfg_i.factor : 2'h0);
	end

	always_ff @(posedge clk_i)
	begin
		if (in_if.valid)
			acc_mem[idx] <= total;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			col_reg <= '0;
			kpos_reg <= 3'h0;
			krow_reg <= 3'h0;
		end
		else if (in_if.valid)
		begin
			col_reg <= cur_col + 1'b1;
			kpos_reg <= (cur_kpos == wrap) ? 3'h0 : cur_kpos + 3'h1;
			krow_reg <= cur_krow;
		end
	end

	// frame and line marks ride on the next pixel actually emitted
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sof_pend_reg <= 1'b0;
			sol_pend_reg <= 1'b0;
		end
		else
		begin
			sof_pend_reg <= (sof_pend_reg || (in_if.valid && in_if.sof)) && !emit;
			sol_pend_reg <= (sol_pend_reg || (in_if.valid && in_if.sol)) && !emit;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			out_if.valid <= 1'b0;
			out_if.data <= '0;
			out_if.sof <= 1'b0;
			out_if.sol <= 1'b0;
		end
		else
		begin
			out_if.valid <= emit;
			out_if.sof <= emit && (sof_pend_reg || in_if.sof);
			out_if.sol <= emit && (sol_pend_reg || in_if.sol);
			if (emit)
				// sum and weight only reach the data through the combine path
				out_if.data <= cfg_i.combine ? pbdr_pkg::bin_final(cfg_i, total) :
					in_if.data;
		end
	end

endmodule // pbdr_bin_stage

// File: src/pbdr_pix_if.sv
`timescale 1ns/1ps
`include "pbdr_regs.svh"

interface pbdr_pix_if;
	logic valid;
	logic [`PBDR_PIX_W-1:0] data;
	logic sof;
	logic sol;
	modport src(output valid, output data, output sof, output sol);
	modport snk(input valid, input data, input sof, input sol);
endinterface // pbdr_pix_if

// File: src/pbdr_pkg.sv
`include "pbdr_regs.svh"

package pbdr_pkg;

	typedef struct packed {
		logic [1:0] factor;
		logic combine;
		logic sum;
		logic weight;
	} pbdr_bin_cfg_t;

	typedef enum logic [1:0] {
		PBDR_RUN = 2'b00,
		PBDR_FLUSH1 = 2'b01,
		PBDR_FLUSH2 = 2'b11
	} pbdr_flush_t;

	typedef enum logic [2:0] {
		PBDR_SEL_NONE,
		PBDR_SEL_HZ,
		PBDR_SEL_VT,
		PBDR_SEL_DC,
		PBDR_SEL_ST
	} pbdr_sel_t;

	// weight of one member of a same-colour group
	function automatic logic [1:0] bin_weight(input pbdr_bin_cfg_t cfg, input logic [1:0] member,
		input logic phase);
		logic [1:0] m3;
		logic [1:0] m4;
		m3 = phase ? 2'h2 - member : member;
		m4 = phase ? 2'h3 - member : member;
		bin_weight = 2'h1;
		if (!cfg.sum && cfg.factor == 2'b10)
		begin
			if (cfg.weight)
				bin_weight = (m3 == 2'h0) ? 2'h2 : 2'h1;
			else
				bin_weight = (member == 2'h1) ? 2'h2 : 2'h1;
		end
		else if (!cfg.sum && cfg.weight && cfg.factor == 2'b11)
			bin_weight = (m4 == 2'h0) ? 2'h3 : (m4 == 2'h3) ? 2'h1 : 2'h2;
	endfunction

	// weights always total a power of two, so the average is a shift
	function automatic logic [`PBDR_PIX_W-1:0] bin_final(input pbdr_bin_cfg_t cfg,
		input logic [`PBDR_ACC_W-1:0] total);
		logic [`PBDR_ACC_W-1:0] res;
		res = total;
		if (!cfg.sum)
		begin
			case (cfg.factor)
				2'b01: res = total >> 1;
				2'b10: res = total >> 2;
				2'b11: res = cfg.weight ? total >> 3 : total >> 2;
				default: res = total;
			endcase
		end
		bin_final = (res > `PBDR_ACC_W'(`PBDR_PIX_MAX)) ? `PBDR_PIX_MAX : res[`PBDR_PIX_W-1:0];
	endfunction

endpackage

// File: src/pbdr_regs.svh
`ifndef PBDR_REGS_SVH
`define PBDR_REGS_SVH

`define PBDR_PIX_W 12
`define PBDR_ACC_W 15
`define PBDR_PIX_MAX 12'hfff
`define PBDR_CNT_W 16
`define PBDR_CNT_MAX 16'hffff

// register indices; byte address is four times the index
`define PBDR_HZ_IDX 10'h036
`define PBDR_VT_IDX 10'h037
`define PBDR_DC_IDX 10'h038
`define PBDR_ST_IDX 10'h039
`define PBDR_ADDR_W 12
`define PBDR_ADDR(idx) {idx, 2'b00}
`define PBDR_CTRL_RST 8'h00
`define PBDR_DC_RST 2'h0

// zoom control fields (horizontal and vertical share positions)
`define PBDR_F_FACT1 1:0
`define PBDR_F_COMB1 2
`define PBDR_F_WEIGHT 3
`define PBDR_F_FACT2 5:4
`define PBDR_F_COMB2 6
`define PBDR_F_SUM 7
`define PBDR_F_DC_EN 0
`define PBDR_F_DC_THR 1
`define PBDR_F_DC 1:0
`define PBDR_F_CTRL 7:0
`define PBDR_F_ST_PEND 16
`define PBDR_THR_HI 11:8
`define PBDR_FACT_NONE 2'b00
`define PBDR_FACT_RSVD 2'b11

`endif

// File: src/pbdr_top.sv
// Functional notes
// - first horizontal factor: none, 2, 3, 4
// - second horizontal factor: none, 2, 3
// - each horizontal stage bins or skips independently
// - sum bit outputs total without shifting down
// - unweighted bin by three uses 1:2:1
// - weight bit: phase-dependent spatial weights, three/four
// - sum and weight ignored when subsampling
// - only same-colour pixels are ever merged
// - vertical analog factor: none, 2, 3, 4
// - vertical digital factor: none, 2, 3
// - vertical analog and digital choose independently
// - vertical sum and weight affect digital only
// - vertical weight makes digital bin-three spatial
// - enable bit runs defect concealment, else pass
// - replace pixel outside neighbour minimum or maximum
// - threshold mode needs difference in top nibble
`timescale 1ns/1ps
`include "pbdr_regs.svh"

module pbdr_top #(
	parameter int MAX_W = 2048
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`PBDR_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pix_valid_i,
	input wire logic [`PBDR_PIX_W-1:0] pix_data_i,
	input wire logic pix_frame_start_i,
	input wire logic pix_line_start_i,
	input wire logic pix_line_end_i,
	output logic pix_valid_o,
	output logic [`PBDR_PIX_W-1:0] pix_data_o,
	output logic pix_frame_start_o,
	output logic pix_line_start_o
);
	logic [7:0] horizontal_zoom_control_reg;
	logic [7:0] vertical_zoom_control_reg;
	logic [1:0] defect_conceal_control_reg;
	logic [7:0] hz_act_reg;
	logic [7:0] vt_act_reg;
	logic [1:0] dc_act_reg;
	logic [`PBDR_CNT_W-1:0] repl_cnt_reg;
	logic [31:0] rd_data;
	pbdr_pkg::pbdr_sel_t rd_sel;
	pbdr_pkg::pbdr_sel_t wr_sel;
	logic wr_en;
	logic cfg_pend;

	pbdr_pkg::pbdr_flush_t flush_reg;
	pbdr_pkg::pbdr_flush_t flush_next;
	logic [`PBDR_PIX_W-1:0] win_data [4];
	logic [3:0] win_vld;
	logic [3:0] win_sof;
	logic [3:0] win_sol;
	logic shift;
	logic [`PBDR_PIX_W-1:0] ctr;
	logic [`PBDR_PIX_W-1:0] nb_max;
	logic [`PBDR_PIX_W-1:0] nb_min;
	logic [`PBDR_PIX_W-1:0] diff_hi;
	logic [`PBDR_PIX_W-1:0] diff_lo;
	logic have_nb;
	logic repl_hi;
	logic repl_lo;

	pbdr_pkg::pbdr_bin_cfg_t h1_cfg;
	pbdr_pkg::pbdr_bin_cfg_t h2_cfg;
	pbdr_pkg::pbdr_bin_cfg_t va_cfg;
	pbdr_pkg::pbdr_bin_cfg_t vd_cfg;

	pbdr_pix_if dc_if();
	pbdr_pix_if h1_if();
	pbdr_pix_if h2_if();
	pbdr_pix_if va_if();
	pbdr_pix_if vd_if();

	function automatic pbdr_pkg::pbdr_sel_t addr_sel(input logic [`PBDR_ADDR_W-1:0] addr);
		if (addr == `PBDR_ADDR(`PBDR_HZ_IDX))
			addr_sel = pbdr_pkg::PBDR_SEL_HZ;
		else if (addr == `PBDR_ADDR(`PBDR_VT_IDX))
			addr_sel = pbdr_pkg::PBDR_SEL_VT;
		else if (addr == `PBDR_ADDR(`PBDR_DC_IDX))
			addr_sel = pbdr_pkg::PBDR_SEL_DC;
		else if (addr == `PBDR_ADDR(`PBDR_ST_IDX))
			addr_sel = pbdr_pkg::PBDR_SEL_ST;
		else
			addr_sel = pbdr_pkg::PBDR_SEL_NONE;
	endfunction

	// register bus: one wait-free access, answers prepared in setup
	always_comb
	begin
		rd_sel = addr_sel(paddr_i);
		wr_sel = rd_sel;
		wr_en = psel_i && penable_i && pready_o && pwrite_i;
		cfg_pend = (horizontal_zoom_control_reg != hz_act_reg) ||
			(vertical_zoom_control_reg != vt_act_reg) ||
			(defect_conceal_control_reg != dc_act_reg);
		rd_data = 32'h0;
		case (rd_sel)
			pbdr_pkg::PBDR_SEL_HZ: rd_data[`PBDR_F_CTRL] = horizontal_zoom_control_reg;
			pbdr_pkg::PBDR_SEL_VT: rd_data[`PBDR_F_CTRL] = vertical_zoom_control_reg;
			pbdr_pkg::PBDR_SEL_DC: rd_data[`PBDR_F_DC] = defect_conceal_control_reg;
			pbdr_pkg::PBDR_SEL_ST:
			begin
				rd_data[`PBDR_CNT_W-1:0] = repl_cnt_reg;
				rd_data[`PBDR_F_ST_PEND] = cfg_pend;
			end
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end
		else if (psel_i && !penable_i)
		begin
			pready_o <= 1'b1;
			pslverr_o <= (rd_sel == pbdr_pkg::PBDR_SEL_NONE);
			prdata_o <= pwrite_i ? 32'h0 : rd_data;
		end
		else
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			horizontal_zoom_control_reg <= `PBDR_CTRL_RST;
			vertical_zoom_control_reg <= `PBDR_CTRL_RST;
			defect_conceal_control_reg <= `PBDR_DC_RST;
		end
		else if (wr_en)
		begin
			if (wr_sel == pbdr_pkg::PBDR_SEL_HZ)
				horizontal_zoom_control_reg <= pwdata_i[`PBDR_F_CTRL];
			else if (wr_sel == pbdr_pkg::PBDR_SEL_VT)
				vertical_zoom_control_reg <= pwdata_i[`PBDR_F_CTRL];
			else if (wr_sel == pbdr_pkg::PBDR_SEL_DC)
				defect_conceal_control_reg <= pwdata_i[`PBDR_F_DC];
		end
	end

	// the pipeline only ever sees the copy taken at frame start
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			hz_act_reg <= `PBDR_CTRL_RST;
			vt_act_reg <= `PBDR_CTRL_RST;
			dc_act_reg <= `PBDR_DC_RST;
		end
		else if (pix_valid_i && pix_frame_start_i)
		begin
			hz_act_reg <= horizontal_zoom_control_reg;
			vt_act_reg <= vertical_zoom_control_reg;
			dc_act_reg <= defect_conceal_control_reg;
		end
	end

	// two dummy shifts after each line end push the last pixels out
	always_comb
	begin
		flush_next = flush_reg;
		case (flush_reg)
			pbdr_pkg::PBDR_RUN:
				if (pix_valid_i && pix_line_end_i)
					flush_next = pbdr_pkg::PBDR_FLUSH1;
			pbdr_pkg::PBDR_FLUSH1: flush_next = pbdr_pkg::PBDR_FLUSH2;
			pbdr_pkg::PBDR_FLUSH2: flush_next = pbdr_pkg::PBDR_RUN;
			default: flush_next = pbdr_pkg::PBDR_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			flush_reg <= pbdr_pkg::PBDR_RUN;
		else
			flush_reg <= flush_next;
	end

	assign shift = pix_valid_i || (flush_reg != pbdr_pkg::PBDR_RUN);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			win_vld <= 4'h0;
			win_sof <= 4'h0;
			win_sol <= 4'h0;
		end
		else if (shift)
		begin
			win_vld <= {win_vld[2:0], pix_valid_i};
			win_sof <= {win_sof[2:0], pix_valid_i && pix_frame_start_i};
			win_sol <= {win_sol[2:0], pix_valid_i && pix_line_start_i};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (shift)
		begin
			win_data[0] <= pix_data_i;
			for (int i = 1; i < 4; i++)
				win_data[i] <= win_data[i-1];
		end
	end

	// centre is two back; same-colour neighbours are two either side
	always_comb
	begin
		ctr = win_data[1];
		have_nb = win_vld[3] || pix_valid_i;
		if (win_vld[3] && pix_valid_i)
		begin
			nb_max = (win_data[3] > pix_data_i) ? win_data[3] : pix_data_i;
			nb_min = (win_data[3] < pix_data_i) ? win_data[3] : pix_data_i;
		end
		else if (win_vld[3])
		begin
			nb_max = win_data[3];
			nb_min = win_data[3];
		end
		else
		begin
			nb_max = pix_data_i;
			nb_min = pix_data_i;
		end
		diff_hi = ctr - nb_max;
		diff_lo = nb_min - ctr;
		repl_hi = dc_act_reg[`PBDR_F_DC_EN] && have_nb && (ctr > nb_max) &&
			(!dc_act_reg[`PBDR_F_DC_THR] || |diff_hi[`PBDR_THR_HI]);
		repl_lo = dc_act_reg[`PBDR_F_DC_EN] && have_nb && (ctr < nb_min) &&
			(!dc_act_reg[`PBDR_F_DC_THR] || |diff_lo[`PBDR_THR_HI]);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			dc_if.valid <= 1'b0;
			dc_if.data <= '0;
			dc_if.sof <= 1'b0;
			dc_if.sol <= 1'b0;
		end
		else
		begin
			dc_if.valid <= shift && win_vld[1];
			dc_if.sof <= shift && win_sof[1];
			dc_if.sol <= shift && win_sol[1];
			if (shift && win_vld[1])
				// enable clear leaves both replace terms low: plain pass
				dc_if.data <= repl_hi ? nb_max : repl_lo ? nb_min : ctr;
		end
	end

	// count restarts with each frame's first centre pixel
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			repl_cnt_reg <= '0;
		else if (shift && win_vld[1])
		begin
			if (win_sof[1])
				repl_cnt_reg <= (repl_hi || repl_lo) ? `PBDR_CNT_W'(1) : '0;
			else if ((repl_hi || repl_lo) && repl_cnt_reg != `PBDR_CNT_MAX)
				repl_cnt_reg <= repl_cnt_reg + 1'b1;
		end
	end

	always_comb
	begin
		h1_cfg = '{hz_act_reg[`PBDR_F_FACT1], hz_act_reg[`PBDR_F_COMB1],
			hz_act_reg[`PBDR_F_SUM], hz_act_reg[`PBDR_F_WEIGHT]};
		h2_cfg = '{hz_act_reg[`PBDR_F_FACT2], hz_act_reg[`PBDR_F_COMB2],
			hz_act_reg[`PBDR_F_SUM], hz_act_reg[`PBDR_F_WEIGHT]};
		if (hz_act_reg[`PBDR_F_FACT2] == `PBDR_FACT_RSVD)
			h2_cfg.factor = `PBDR_FACT_NONE;
		// analog stage never sees sum or weight
		va_cfg = '{vt_act_reg[`PBDR_F_FACT1], vt_act_reg[`PBDR_F_COMB1], 1'b0, 1'b0};
		vd_cfg = '{vt_act_reg[`PBDR_F_FACT2], vt_act_reg[`PBDR_F_COMB2],
			vt_act_reg[`PBDR_F_SUM], vt_act_reg[`PBDR_F_WEIGHT]};
		if (vt_act_reg[`PBDR_F_FACT2] == `PBDR_FACT_RSVD)
			vd_cfg.factor = `PBDR_FACT_NONE;
	end

	pbdr_bin_stage #(.VERT(1'b0), .MAX_W(MAX_W)) u_h1 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cfg_i(h1_cfg),
		.in_if(dc_if.snk),
		.out_if(h1_if.src)
	);

	pbdr_bin_stage #(.VERT(1'b0), .MAX_W(MAX_W)) u_h2 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cfg_i(h2_cfg),
		.in_if(h1_if.snk),
		.out_if(h2_if.src)
	);

	pbdr_bin_stage #(.VERT(1'b1), .MAX_W(MAX_W)) u_va (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cfg_i(va_cfg),
		.in_if(h2_if.snk),
		.out_if(va_if.src)
	);

	pbdr_bin_stage #(.VERT(1'b1), .MAX_W(MAX_W)) u_vd (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cfg_i(vd_cfg),
		.in_if(va_if.snk),
		.out_if(vd_if.src)
	);

	// last stage outputs are its own flip-flops
	assign pix_valid_o = vd_if.valid;
	assign pix_data_o = vd_if.data;
	assign pix_frame_start_o = vd_if.sof;
	assign pix_line_start_o = vd_if.sol;

endmodule // pbdr_top

// File: tb/pbdr_pix_model.sv
`timescale 1ns/1ps

module pbdr_pix_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [7:0] width_i,
	input wire logic [7:0] rows_i,
	input wire logic [7:0] gap_i,
	output logic valid_o,
	output logic [11:0] data_o,
	output logic frame_start_o,
	output logic line_start_o,
	output logic line_end_o,
	output logic busy_o
);
	int img [0:15][0:31];
	initial
	begin
		valid_o = 1'b0;
		data_o = 12'h000;
		frame_start_o = 1'b0;
		line_start_o = 1'b0;
		line_end_o = 1'b0;
		busy_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (start_i === 1'b1)
			begin
				busy_o <= 1'b1;
				for (int y = 0; y < rows_i; y++)
					for (int x = 0; x < width_i; x++)
					begin
						valid_o <= 1'b1;
						data_o <= img[y][x][11:0];
						frame_start_o <= (x == 0 && y == 0);
						line_start_o <= (x == 0);
						line_end_o <= (x == width_i - 1);
						@(posedge clk_i);
						if (x == width_i - 1 || gap_i != 8'h00)
						begin
							valid_o <= 1'b0;
							frame_start_o <= 1'b0;
							line_start_o <= 1'b0;
							line_end_o <= 1'b0;
							// idle data shows the inverse, never a stale pixel
							data_o <= ~img[y][x][11:0];
							// row end needs at least two flush cycles
							repeat (x == width_i - 1 ? 3 : gap_i) @(posedge clk_i);
						end
					end
				busy_o <= 1'b0;
			end
		end
	end
endmodule // pbdr_pix_model

// File: tb/pbdr_top_asserts.sv
`timescale 1ns/1ps
`include "pbdr_regs.svh"

module pbdr_top_asserts (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [`PBDR_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic pix_valid_i,
	input wire logic pix_valid_o,
	input wire logic pix_frame_start_o,
	input wire logic pix_line_start_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [5:0] idle_reg;
	logic setup;
	logic mapped;
	assign setup = psel_i && !penable_i;
	assign mapped = paddr_i inside {`PBDR_ADDR(`PBDR_HZ_IDX), `PBDR_ADDR(`PBDR_VT_IDX),
		`PBDR_ADDR(`PBDR_DC_IDX), `PBDR_ADDR(`PBDR_ST_IDX)};
	// saturates so a long idle span cannot wrap below the bound
	always_ff @(posedge clk_i)
	begin
		if (reset_i || pix_valid_i)
			idle_reg <= 6'h00;
		else if (idle_reg != 6'h3f)
			idle_reg <= idle_reg + 6'h01;
	end
	property p_ready_after_setup;
		setup |=> pready_o;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
	property p_ready_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	property p_ready_cause;
		pready_o |-> $past(setup);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_err_unmapped;
		setup && !mapped |-> ##1 pslverr_o && prdata_o == 32'h00000000;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
	property p_no_err_mapped;
		setup && mapped |=> !pslverr_o;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped refused");
	property p_frame_start_line;
		pix_frame_start_o |-> pix_line_start_o && pix_valid_o;
	endproperty
	a_frame_start_line: assert property (p_frame_start_line) else $error("frame start alone");
	property p_line_start_valid;
		pix_line_start_o |-> pix_valid_o;
	endproperty
	a_line_start_valid: assert property (p_line_start_valid) else $error("line start no pixel");
	property p_out_near_in;
		pix_valid_o |-> idle_reg < 6'h1e;
	endproperty
	a_out_near_in: assert property (p_out_near_in) else $error("pixel out of nowhere");
endmodule // pbdr_top_asserts

// File: tb/tb.sv
`timescale 1ns/1ps
`include "pbdr_regs.svh"

module tb;
	localparam logic [11:0] HZ = `PBDR_ADDR(`PBDR_HZ_IDX);
	localparam logic [11:0] VT = `PBDR_ADDR(`PBDR_VT_IDX);
	localparam logic [11:0] DC = `PBDR_ADDR(`PBDR_DC_IDX);
	localparam logic [11:0] ST = `PBDR_ADDR(`PBDR_ST_IDX);
	logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [11:0] paddr_i, pix_data_i, pix_data_o;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pix_valid_i, pix_frame_start_i, pix_line_start_i, pix_line_end_i;
	logic pix_valid_o, pix_frame_start_o, pix_line_start_o, start, busy;
	logic [7:0] w8, r8, g8, hz_v, vt_v, dc_v;
	int fails, comparisons, nfs, nls, oh, nrep;
	int img [0:15][0:31];
	int exp_q[$];
	logic [11:0] got_q[$];
	logic [11:0] ra[3] = '{HZ, VT, DC};
	logic [31:0] rm[3] = '{32'h000000ff, 32'h000000ff, 32'h00000003};
	logic [15:0] cf[17] = '{16'h0000, 16'h0500, 16'h0100, 16'h8a00, 16'h0600, 16'h0e00,
		16'h0700, 16'h0f00, 16'h8500, 16'h8700, 16'h5500, 16'h2500, 16'h0505, 16'h008d,
		16'h0086, 16'h0068, 16'h0051};
	logic [31:0] dq[4] = '{32'h004013ff, 32'h014013ff, 32'h034ff300, 32'h03500301};

	pbdr_top #(.MAX_W(32)) dut_u (.*);
	pbdr_pix_model pm_u (.clk_i(clk_i), .start_i(start), .width_i(w8), .rows_i(r8),
		.gap_i(g8), .valid_o(pix_valid_i), .data_o(pix_data_i), .frame_start_o(pix_frame_start_i),
		.line_start_o(pix_line_start_i), .line_end_o(pix_line_end_i), .busy_o(busy));

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (pix_valid_o === 1'b1)
		begin
			got_q.push_back(pix_data_o);
			nfs += pix_frame_start_o;
			nls += pix_line_start_o;
		end

	task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_pix(input logic [11:0] e, input logic [11:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED pixel expected %h seen %h", e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no wait-state count assumed; a hang is left to the watchdog
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic set(input logic [7:0] h, input logic [7:0] v, input logic [7:0] d);
		hz_v = h;
		vt_v = v;
		dc_v = d;
		apb(1'b1, HZ, {24'h000000, h});
		apb(1'b1, VT, {24'h000000, v});
		apb(1'b1, DC, {24'h000000, d});
	endtask

	function automatic int wt(int n, int m, int p, logic w);
		int mm;
		mm = p ? n - 1 - m : m;
		if (n == 3)
			return w ? (mm == 0 ? 2 : 1) : (m == 1 ? 2 : 1);
		if (n == 4 && w)
			return mm == 0 ? 3 : (mm == 3 ? 1 : 2);
		return 1;
	endfunction

	// same-phase groups of 2n; skip keeps member 0, groups cut short are dropped
	function automatic void red(ref int v[$], input logic [1:0] f, input logic two,
		input logic c, input logic w, input logic s);
		int o[$];
		int n, acc;
		n = (two && f == 2'h3) ? 1 : int'(f) + 1;
		if (n == 1)
			return;
		for (int g = 0; (g + 1) * 2 * n <= v.size(); g++)
			for (int p = 0; p < 2; p++)
			begin
				acc = 0;
				for (int m = 0; m < n; m++)
					acc += (s ? 1 : wt(n, m, p, w)) * v[g * 2 * n + 2 * m + p];
				if (!c)
					acc = v[g * 2 * n + p];
				else if (!s)
					acc = acc >> (n == 2 ? 1 : (n == 4 && w ? 3 : 2));
				o.push_back(acc > 4095 ? 4095 : acc);
			end
		v = o;
	endfunction

	task automatic build(input int w, input int r);
		int q[$];
		int m[0:31][$];
		int mx, mn, a, b;
		exp_q.delete();
		nrep = 0;
		for (int y = 0; y < r; y++)
		begin
			q.delete();
			for (int x = 0; x < w; x++)
				q.push_back(img[y][x]);
			for (int x = 0; x < w && dc_v[0]; x++)
			begin
				// row-edge pixels are judged on their one same-colour neighbour
				a = img[y][x < 2 ? x + 2 : x - 2];
				b = img[y][x + 2 < w ? x + 2 : x - 2];
				mx = a > b ? a : b;
				mn = a < b ? a : b;
				if (img[y][x] > mx && (!dc_v[1] || img[y][x] - mx >= 256))
				begin
					q[x] = mx;
					nrep++;
				end
				else if (img[y][x] < mn && (!dc_v[1] || mn - img[y][x] >= 256))
				begin
					q[x] = mn;
					nrep++;
				end
			end
			red(q, hz_v[1:0], 1'b0, hz_v[2], hz_v[3], hz_v[7]);
			red(q, hz_v[5:4], 1'b1, hz_v[6], hz_v[3], hz_v[7]);
			foreach (q[x])
				m[x].push_back(q[x]);
		end
		for (int x = 0; x < 32; x++)
		begin
			red(m[x], vt_v[1:0], 1'b0, vt_v[2], 1'b0, 1'b0);
			red(m[x], vt_v[5:4], 1'b1, vt_v[6], vt_v[3], vt_v[7]);
		end
		oh = m[0].size();
		for (int y = 0; y < oh; y++)
			for (int x = 0; x < 32; x++)
				if (m[x].size() > y)
					exp_q.push_back(m[x][y]);
	endtask

	task automatic frame(input int w, input int r, input int g);
		build(w, r);
		got_q.delete();
		nfs = 0;
		nls = 0;
		pm_u.img = img;
		@(posedge clk_i);
		w8 <= 8'(w);
		r8 <= 8'(r);
		g8 <= 8'(g);
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		@(posedge clk_i);
		while (busy === 1'b1)
			@(posedge clk_i);
		repeat (40) @(posedge clk_i);
		chk_reg("pixel count", 32'(exp_q.size()), 32'(got_q.size()));
		chk_reg("frame starts", 32'h1, 32'(nfs));
		chk_reg("line starts", 32'(oh), 32'(nls));
		foreach (exp_q[i])
			if (i < got_q.size())
				chk_pix(exp_q[i][11:0], got_q[i]);
	endtask

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_i);
		fails++;
		conclude();
	end

	initial
	begin
		reset_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h00000000;
		start = 1'b0;
		w8 = 8'h00;
		r8 = 8'h00;
		g8 = 8'h00;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		foreach (ra[i])
		begin
			apb(1'b0, ra[i], 32'h0);
			chk_reg("reset value", 32'h0, rd);
			apb(1'b1, ra[i], 32'hffffffff);
			apb(1'b0, ra[i], 32'h0);
			chk_reg("readback", rm[i], rd);
		end
		apb(1'b1, 12'h0e8, 32'h000000ff);
		chk_reg("write refused", 32'h1, {31'h0, err});
		apb(1'b0, 12'h0e8, 32'h0);
		chk_reg("read refused", 32'h1, {31'h0, err});
		chk_reg("refused data", 32'h0, rd);
		foreach (img[y, x])
			img[y][x] = (x * 137 + y * 211 + 300) % 4096;
		foreach (cf[i])
		begin
			set(cf[i][15:8], cf[i][7:0], 8'h00);
			frame(24, 12, i % 3);
		end
		for (int x = 0; x < 12; x++)
			img[0][x] = 'h400;
		foreach (dq[i])
		begin
			img[0][4] = dq[i][23:12];
			img[0][7] = dq[i][11:0];
			set(8'h00, 8'h00, dq[i][31:24]);
			frame(12, 1, 0);
			apb(1'b0, ST, 32'h0);
			chk_reg("replaced", 32'(nrep), {16'h0000, rd[15:0]});
		end
		set(8'h00, 8'h00, 8'h00);
		fork
			frame(24, 4, 0);
			begin
				repeat (30) @(posedge clk_i);
				apb(1'b1, HZ, 32'h00000005);
				apb(1'b0, 12'h0e4, 32'h0);
				chk_reg("pending", 32'h1, {31'h0, rd[16]});
			end
		join
		hz_v = 8'h05;
		frame(24, 4, 0);
		conclude();
	end
endmodule // tb

bind pbdr_top pbdr_top_asserts chk_u (.*);
